// >>> dv/plo_phy_model.sv
// Behavioural attached PHY and integrated PHY outputs.
// Assumes the bench presents new values on clk_sys.
`timescale 1ns/1ns
module plo_phy_model
  import plo_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Values to present.
  input plo_poll_t [NUM_STAT-1:0] pollIn,
  input plo_link_t [NUM_OVR-1:0] phyIn,
  input wire logic [NUM_STAT-1:0] rxIn,
  input wire logic [NUM_STAT-1:0] txIn,
  // Toward the register bank.
  output plo_poll_t [NUM_STAT-1:0] pollResult,
  output plo_link_t [NUM_OVR-1:0] phyLinkInfo,
  output logic [NUM_STAT-1:0] rxTraffic,
  output logic [NUM_STAT-1:0] txTraffic
);
  // Results only move on a clock edge, as a finished poll would deliver them.
  always_ff @(posedge clk_sys) begin
    pollResult <= rst_n ? pollIn : '0;
    phyLinkInfo <= rst_n ? phyIn : '0;
    rxTraffic <= rst_n ? rxIn : '0;
    txTraffic <= rst_n ? txIn : '0;
  end
endmodule

// >>> dv/tb.sv
// Self-checking bench of the port link override register bank.
// Assumes the design and the PHY model files are compiled first.
`timescale 1ns/1ns
module tb
  import plo_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, pollEnable, irq, pe;
  plo_poll_t [NUM_STAT-1:0] pollIn = '0, pollResult;
  plo_link_t [NUM_OVR-1:0] phyIn = '0, phyLinkInfo, portLinkInfo;
  logic [NUM_STAT-1:0] rxIn = '0, txIn = '0, rxTraffic, txTraffic;
  logic [NUM_OVR-1:0][4:0] portPhyAddr;
  logic [15:0] ovrExp [2];
  logic [15:0] sIdx [4] = '{IDX_STAT_P1, IDX_STAT_P2, IDX_STAT_P3, IDX_STAT_P5};
  logic [15:0] rIdx [6] = '{IDX_OVR_P2, IDX_OVR_P1, IDX_CTRL, IDX_STAT_P1, IDX_IRQ_STAT,
    IDX_IRQ_EN};
  logic [15:0] rVal [6] = '{16'h1802, 16'h1801, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  logic [31:0] rnd = 32'h0264A368;
  int err_total = 0, cmp_count = 0, cyc = 0, i, j, k;

  always #2 clk_sys = ~clk_sys;

  plo_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pollResult(pollResult), .rxTraffic(rxTraffic),
    .txTraffic(txTraffic), .phyLinkInfo(phyLinkInfo), .portLinkInfo(portLinkInfo),
    .portPhyAddr(portPhyAddr), .pollEnable(pollEnable), .irq(irq));

  plo_phy_model phy (.clk_sys(clk_sys), .rst_n(rst_n), .pollIn(pollIn), .phyIn(phyIn),
    .rxIn(rxIn), .txIn(txIn), .pollResult(pollResult), .phyLinkInfo(phyLinkInfo),
    .rxTraffic(rxTraffic), .txTraffic(txTraffic));

  // ************************************************************
  // Reference model and helpers.
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // Reserved codes fall through every branch, so they act as automatic.
  function automatic plo_link_t resolve(plo_ovr_t o, logic en, plo_link_t pl, plo_link_t ph);
    plo_link_t s;
    s = o.srcSel ? ph : pl;
    if (en) return s;
    if (o.linkStateOverride == LNK_UP) s.link = 1'b1;
    if (o.linkStateOverride == LNK_DOWN) s.link = 1'b0;
    if (o.speed != SPD_AUTO) s.speed = o.speed;
    if (o.duplexOverride == DUP_FULL) s.fullDuplex = 1'b1;
    if (o.duplexOverride == DUP_HALF) s.fullDuplex = 1'b0;
    if (o.txPauseMode == PAU_ING) s.partnerAcceptsPause = 1'b0;
    if (o.txPauseMode == PAU_EGR) s.partnerAcceptsPause = 1'b1;
    if (o.rxPauseMode == PAU_ING) s.partnerSendsPause = 1'b1;
    if (o.rxPauseMode == PAU_EGR) s.partnerSendsPause = 1'b0;
    return s;
  endfunction

  // Software keeps reserved override codes out of the registers.
  function automatic logic [15:0] legal(input logic [15:0] v);
    plo_ovr_t o;
    o = v;
    if (o.linkStateOverride == 2'h3) o.linkStateOverride = 2'h0;
    if (o.duplexOverride == 2'h2) o.duplexOverride = 2'h0;
    if (o.txPauseMode == 2'h2) o.txPauseMode = 2'h0;
    if (o.rxPauseMode == 2'h2) o.rxPauseMode = 2'h0;
    return o;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
      input logic expErr, output logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    data = prdata;
    check({31'h0, pslverr}, {31'h0, expErr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A hang costs one mismatch rather than an endless run.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      stop_test();
    end
  end

  // ************************************************************
  // Scenarios.
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, rIdx[i], 32'h0, 1'b0, rd);
      check(rd, {16'h0, rVal[i]});
    end
    check({22'h0, portPhyAddr}, {22'h0, 5'h02, 5'h01});
    apb(1'b1, 16'hF41A, 32'hFFFF, 1'b1, rd);
    apb(1'b0, 16'hF41A, 32'h0, 1'b1, rd);
    check(rd, 32'h0);
    ovrExp = '{16'h1801, 16'h1802};
    for (i = 0; i < 64; i++) begin
      k = i % 2;
      rnd = lfsr(rnd);
      pollIn <= {rnd[3:0], rnd};
      rnd = lfsr(rnd);
      phyIn <= rnd[11:0];
      ovrExp[k] = legal(rnd[31:16]);
      pe = rnd[13] & rnd[14];
      apb(1'b1, k ? IDX_OVR_P2 : IDX_OVR_P1, {16'h0, ovrExp[k]}, 1'b0, rd);
      apb(1'b1, IDX_CTRL, {31'h0, pe}, 1'b0, rd);
      repeat (2) @(posedge clk_sys);
      for (j = 0; j < 2; j++) begin
        check({26'h0, portLinkInfo[j]},
          {26'h0, resolve(ovrExp[j], pe, pollIn[j][5:0], phyIn[j])});
        check({27'h0, portPhyAddr[j]}, {27'h0, ovrExp[j][4:0]});
      end
      check({31'h0, pollEnable}, {31'h0, pe});
      apb(1'b0, k ? IDX_OVR_P2 : IDX_OVR_P1, 32'h0, 1'b0, rd);
      check(rd, {16'h0, ovrExp[k]});
      apb(1'b0, sIdx[i % 4], 32'h0, 1'b0, rd);
      check(rd, {23'h0, pollIn[i % 4]});
    end
    // A reset in mid-run must bring the written overrides back to their defaults.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 3; i++) begin
      apb(1'b0, rIdx[i], 32'h0, 1'b0, rd);
      check(rd, {16'h0, rVal[i]});
    end
    check({22'h0, portPhyAddr}, {22'h0, 5'h02, 5'h01});
    // Receive traffic stays on through the first clear, so that clear must lose.
    for (j = 0; j < 4; j++) begin
      rxIn[j] <= 1'b1;
      txIn[j] <= 1'b1;
      @(posedge clk_sys);
      txIn <= '0;
      repeat (3) @(posedge clk_sys);
      apb(1'b0, sIdx[j], 32'h0, 1'b0, rd);
      check(rd, {21'h0, 2'b11, pollIn[j]});
      apb(1'b1, sIdx[j], 32'h600, 1'b0, rd);
      apb(1'b0, sIdx[j], 32'h0, 1'b0, rd);
      check(rd, {21'h0, 2'b10, pollIn[j]});
      rxIn <= '0;
      apb(1'b1, sIdx[j], 32'h400, 1'b0, rd);
      apb(1'b0, sIdx[j], 32'h0, 1'b0, rd);
      check(rd, {21'h0, 2'b00, pollIn[j]});
    end
    apb(1'b0, IDX_IRQ_STAT, 32'h0, 1'b0, rd);
    check(rd, 32'hFF);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, IDX_IRQ_EN, 32'h10, 1'b0, rd);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, IDX_IRQ_CLR, 32'h10, 1'b0, rd);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, IDX_IRQ_STAT, 32'h0, 1'b0, rd);
    check(rd, 32'hEF);
    apb(1'b0, IDX_IRQ_CLR, 32'h0, 1'b0, rd);
    check(rd, 32'h0);
    stop_test();
  end
endmodule

// >>> rtl/plo_ovr_mux.sv
// Resolves one port's final link information from its override register.
// Assumes both automatic sources are synchronous to clk_sys.
`timescale 1ns/1ns
module plo_ovr_mux
  import plo_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration.
  input wire logic pollEnable,
  input plo_ovr_t ovr,
  // Automatic sources.
  input plo_link_t polledInfo,
  input plo_link_t phyInfo,
  // Result.
  output plo_link_t finalInfo
);

  plo_link_t autoInfo;
  plo_link_t finalNext;

  always_comb begin
    autoInfo = ovr.srcSel ? phyInfo : polledInfo; // R2
    finalNext = autoInfo;
    if (!pollEnable) begin // R1
      // Reserved codes fall through to the automatic value.
      case (ovr.linkStateOverride) // R3 R13
        LNK_UP: finalNext.link = 1'b1;
        LNK_DOWN: finalNext.link = 1'b0;
        default: finalNext.link = autoInfo.link;
      endcase
      if (ovr.speed != SPD_AUTO) begin // R4
        finalNext.speed = ovr.speed;
      end
      case (ovr.duplexOverride) // R5
        DUP_FULL: finalNext.fullDuplex = 1'b1;
        DUP_HALF: finalNext.fullDuplex = 1'b0;
        default: finalNext.fullDuplex = autoInfo.fullDuplex;
      endcase
      case (ovr.txPauseMode) // R6
        PAU_ING: finalNext.partnerAcceptsPause = 1'b0;
        PAU_EGR: finalNext.partnerAcceptsPause = 1'b1;
        default: finalNext.partnerAcceptsPause = autoInfo.partnerAcceptsPause;
      endcase
      case (ovr.rxPauseMode) // R7
        PAU_ING: finalNext.partnerSendsPause = 1'b1;
        PAU_EGR: finalNext.partnerSendsPause = 1'b0;
        default: finalNext.partnerSendsPause = autoInfo.partnerSendsPause;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      finalInfo <= '0;
    end else begin
      finalInfo <= finalNext;
    end
  end

  AST_FORCE_UP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    (!pollEnable && ovr.linkStateOverride == LNK_UP) |=> finalInfo.link)
    else $error("Forced link up not applied.");

  AST_SPEED_FORCE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (!pollEnable && ovr.speed != SPD_AUTO) |=> finalInfo.speed == $past(ovr.speed))
    else $error("Forced speed not applied.");

  AST_POLL_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (pollEnable && !ovr.srcSel) |=> finalInfo == $past(polledInfo))
    else $error("Polled info not passed while polling.");

  AST_SRC_PHY: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    (pollEnable && ovr.srcSel) |=> finalInfo == $past(phyInfo))
    else $error("Integrated PHY source not selected.");

endmodule

// >>> rtl/plo_pkg.sv
// Constants, field layouts and carrier types of the port link override register bank.
// Assumes one 250 MHz clock, a synchronous active-low reset and an APB master.
//
// Notes on behaviour
// [R1] With autopolling disabled, override fields replace the polled link values.
// [R2] Bit 15 picks the automatic source: 0 polling results, 1 integrated PHY.
// [R3] Link field 14:13: 00 automatic, 01 forced up, 10 forced down, 11 reserved.
// [R4] Speed field 12:11: 00 10M, 01 100M, 10 1G, 11 automatic.
// [R5] Duplex field 10:9: 00 automatic, 01 full, 10 reserved, 11 half.
// [R6] Transmit pause field 8:7: 00 automatic, 01 ingress only, 11 egress only.
// [R7] Receive pause field 6:5 uses the transmit pause encoding.
// [R8] Bits 4:0 hold the read-write PHY address used for that port.
// [R9] Override registers reset to 1801 and 1802 for ports 1 and 2.
// [R10] Polled status registers for ports 1, 2, 3, 5 share one layout.
// [R11] Activity flags set by traffic, cleared by writing one; set wins.
// [R12] Polled link, speed, duplex and pause bits follow the PHY polling results.
// [R13] Software never writes reserved encodings; the block treats them as automatic.
package plo_pkg;

  // ************************************************************
  // Register map, byte addresses are four times the index.
  // ************************************************************
  localparam logic [15:0] IDX_OVR_P2 = 16'hF413;
  localparam logic [15:0] IDX_OVR_P1 = 16'hF414;
  localparam logic [15:0] IDX_STAT_P1 = 16'hF417;
  localparam logic [15:0] IDX_STAT_P2 = 16'hF418;
  localparam logic [15:0] IDX_STAT_P3 = 16'hF419;
  localparam logic [15:0] IDX_STAT_P5 = 16'hF41B;
  localparam logic [15:0] IDX_CTRL = 16'hF41C;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hF41D;
  localparam logic [15:0] IDX_IRQ_EN = 16'hF41E;
  localparam logic [15:0] IDX_IRQ_CLR = 16'hF41F;

  localparam logic [15:0] RST_OVR_P1 = 16'h1801;
  localparam logic [15:0] RST_OVR_P2 = 16'h1802;

  // ************************************************************
  // Field positions and encodings.
  // ************************************************************
  localparam int OVR_SRC = 15;
  localparam int ST_RX_ACTIVITY_FLAG = 10;
  localparam int ST_TX_ACTIVITY_FLAG = 9;
  localparam int CTRL_POLL_EN = 0;
  localparam int NUM_STAT = 4;
  localparam int NUM_OVR = 2;
  localparam int NUM_IRQ = 8;

  localparam logic [1:0] LNK_AUTO = 2'h0;
  localparam logic [1:0] LNK_UP = 2'h1;
  localparam logic [1:0] LNK_DOWN = 2'h2;
  localparam logic [1:0] SPD_AUTO = 2'h3;
  localparam logic [1:0] DUP_FULL = 2'h1;
  localparam logic [1:0] DUP_HALF = 2'h3;
  localparam logic [1:0] PAU_ING = 2'h1;
  localparam logic [1:0] PAU_EGR = 2'h3;

  typedef struct packed {
    logic srcSel;
    logic [1:0] linkStateOverride;
    logic [1:0] speed;
    logic [1:0] duplexOverride;
    logic [1:0] txPauseMode;
    logic [1:0] rxPauseMode;
    logic [4:0] phyAddr;
  } plo_ovr_t;

  // Link information as delivered by a source or driven to the port.
  typedef struct packed {
    logic link;
    logic [1:0] speed;
    logic fullDuplex;
    logic partnerSendsPause;
    logic partnerAcceptsPause;
  } plo_link_t;

  // Raw polled result for one port, bits 8:0 of the status layout.
  typedef struct packed {
    logic clkStopCapable;
    logic eeeCapable;
    logic phyActive;
    logic polledLinkState;
    logic [1:0] speed;
    logic fullDuplex;
    logic partnerSendsPause;
    logic partnerAcceptsPause;
  } plo_poll_t;

  typedef enum logic [1:0] {
    APB_IDLE,
    APB_ACCESS
  } plo_apb_state_t;

endpackage

// >>> rtl/plo_regs.sv
// Top of the port link override register bank with APB slave and interrupt.
// Assumes the polling engine delivers per-port results and traffic strobes on clk_sys.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module plo_regs
  import plo_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Polled results for ports 1, 2, 3 and 5, index 0 to 3.
  input plo_poll_t [NUM_STAT-1:0] pollResult,
  input wire logic [NUM_STAT-1:0] rxTraffic,
  input wire logic [NUM_STAT-1:0] txTraffic,
  // Integrated PHY link outputs for ports 1 and 2, index 0 and 1.
  input plo_link_t [NUM_OVR-1:0] phyLinkInfo,
  // Final link information and PHY addresses for ports 1 and 2.
  output plo_link_t [NUM_OVR-1:0] portLinkInfo,
  output logic [NUM_OVR-1:0][4:0] portPhyAddr,
  output logic pollEnable,
  // Interrupt.
  output logic irq
);

  // ************************************************************
  // APB decode.
  // ************************************************************
  plo_apb_state_t apbState_reg;
  logic [15:0] regIdx;
  logic mapped;
  logic wrEn;
  logic rdEn;
  logic addrBad;

  assign regIdx = paddr[17:2];
  assign mapped = (regIdx == IDX_OVR_P1) || (regIdx == IDX_OVR_P2) ||
                  (regIdx == IDX_STAT_P1) || (regIdx == IDX_STAT_P2) ||
                  (regIdx == IDX_STAT_P3) || (regIdx == IDX_STAT_P5) ||
                  (regIdx == IDX_CTRL) || (regIdx == IDX_IRQ_STAT) ||
                  (regIdx == IDX_IRQ_EN) || (regIdx == IDX_IRQ_CLR);
  // Zero-wait slave: the access phase always completes in its first cycle.
  assign pready = psel && penable;
  assign addrBad = !mapped || paddr[1:0] != 2'h0 || paddr[31:18] != '0;
  assign pslverr = pready && addrBad;
  assign wrEn = pready && pwrite && !pslverr;
  // A read is accepted in its setup cycle, when the address first stands.
  assign rdEn = psel && !penable && !pwrite && !addrBad;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      apbState_reg <= APB_IDLE;
    end else begin
      case (apbState_reg)
        APB_IDLE: apbState_reg <= (psel && !penable) ? APB_ACCESS : APB_IDLE;
        APB_ACCESS: apbState_reg <= (psel && !penable) ? APB_ACCESS : APB_IDLE;
        default: apbState_reg <= APB_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Override and control registers.
  // ************************************************************
  plo_ovr_t [NUM_OVR-1:0] ovr_reg;
  logic pollEnable_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ovr_reg[0] <= plo_ovr_t'(RST_OVR_P1); // R9
      ovr_reg[1] <= plo_ovr_t'(RST_OVR_P2); // R9
    end else if (wrEn && regIdx == IDX_OVR_P1) begin
      ovr_reg[0] <= plo_ovr_t'(pwdata[15:0]); // R8
    end else if (wrEn && regIdx == IDX_OVR_P2) begin
      ovr_reg[1] <= plo_ovr_t'(pwdata[15:0]); // R8
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pollEnable_reg <= 1'b1;
    end else if (wrEn && regIdx == IDX_CTRL) begin
      pollEnable_reg <= pwdata[CTRL_POLL_EN];
    end
  end
  assign pollEnable = pollEnable_reg;

  // ************************************************************
  // Polled status and activity flags.
  // ************************************************************
  plo_poll_t [NUM_STAT-1:0] poll_reg;
  logic [NUM_STAT-1:0] rx_activity_flag_reg;
  logic [NUM_STAT-1:0] tx_activity_flag_reg;
  logic [NUM_STAT-1:0] statHit;
  logic [NUM_STAT-1:0][15:0] statWord;
  localparam logic [NUM_STAT-1:0][15:0] STAT_IDX = {IDX_STAT_P5, IDX_STAT_P3,
                                                    IDX_STAT_P2, IDX_STAT_P1};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STAT; gi++) begin : gStat
      assign statHit[gi] = wrEn && regIdx == STAT_IDX[gi]; // R10
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          poll_reg[gi] <= '0;
        end else begin
          poll_reg[gi] <= pollResult[gi]; // R12
        end
      end
      // A strobe in the cycle of a write-one clear keeps the flag set.
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rx_activity_flag_reg[gi] <= 1'b0;
          tx_activity_flag_reg[gi] <= 1'b0;
        end else begin
          rx_activity_flag_reg[gi] <= rxTraffic[gi] ||
                           (rx_activity_flag_reg[gi] && !(statHit[gi] && pwdata[ST_RX_ACTIVITY_FLAG])); // R11
          tx_activity_flag_reg[gi] <= txTraffic[gi] ||
                           (tx_activity_flag_reg[gi] && !(statHit[gi] && pwdata[ST_TX_ACTIVITY_FLAG])); // R11
        end
      end
      assign statWord[gi] = {5'h00, rx_activity_flag_reg[gi], tx_activity_flag_reg[gi], poll_reg[gi]}; // R10
    end
  endgenerate

  // ************************************************************
  // Final link resolution for ports 1 and 2.
  // ************************************************************
  generate
    for (gi = 0; gi < NUM_OVR; gi++) begin : gMux
      plo_link_t polledInfo;
      assign polledInfo = '{link: poll_reg[gi].polledLinkState,
                            speed: poll_reg[gi].speed,
                            fullDuplex: poll_reg[gi].fullDuplex,
                            partnerSendsPause: poll_reg[gi].partnerSendsPause,
                            partnerAcceptsPause: poll_reg[gi].partnerAcceptsPause};
      plo_ovr_mux uMux (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pollEnable(pollEnable_reg),
        .ovr(ovr_reg[gi]),
        .polledInfo(polledInfo),
        .phyInfo(phyLinkInfo[gi]),
        .finalInfo(portLinkInfo[gi])
      );
      assign portPhyAddr[gi] = ovr_reg[gi].phyAddr; // R8
    end
  endgenerate

  // ************************************************************
  // Interrupt: bits 3:0 rx activity, bits 7:4 tx activity.
  // ************************************************************
  logic [NUM_IRQ-1:0] irqStat_reg;
  logic [NUM_IRQ-1:0] irqEn_reg;
  logic [NUM_IRQ-1:0] irqEvent;
  logic [NUM_IRQ-1:0] irqClr;

  assign irqEvent = {txTraffic, rxTraffic};
  assign irqClr = (wrEn && regIdx == IDX_IRQ_CLR) ? pwdata[NUM_IRQ-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= irqEvent | (irqStat_reg & ~irqClr);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqEn_reg <= '0;
    end else if (wrEn && regIdx == IDX_IRQ_EN) begin
      irqEn_reg <= pwdata[NUM_IRQ-1:0];
    end
  end

  assign irq = |(irqStat_reg & irqEn_reg);

  // ************************************************************
  // Read data, registered at the end of the setup phase.
  // ************************************************************
  logic [31:0] prdata_next;

  always_comb begin
    prdata_next = '0;
    case (regIdx)
      IDX_OVR_P1: prdata_next[15:0] = ovr_reg[0];
      IDX_OVR_P2: prdata_next[15:0] = ovr_reg[1];
      IDX_STAT_P1: prdata_next[15:0] = statWord[0];
      IDX_STAT_P2: prdata_next[15:0] = statWord[1];
      IDX_STAT_P3: prdata_next[15:0] = statWord[2];
      IDX_STAT_P5: prdata_next[15:0] = statWord[3];
      IDX_CTRL: prdata_next[CTRL_POLL_EN] = pollEnable_reg;
      IDX_IRQ_STAT: prdata_next[NUM_IRQ-1:0] = irqStat_reg;
      IDX_IRQ_EN: prdata_next[NUM_IRQ-1:0] = irqEn_reg;
      default: prdata_next = '0;
    endcase
  end

  // Capturing at the setup edge keeps read data in a flip-flop and still needs no wait state.
  // A flag that sets during the access cycle is only seen by the next read.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rdEn) begin
      prdata <= prdata_next;
    end else if (pready) begin
      prdata <= '0;
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  AST_RX_ACTIVITY_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    rxTraffic[0] |=> rx_activity_flag_reg[0])
    else $error("Receive activity flag not set by traffic.");

  AST_TX_ACTIVITY_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (statHit[0] && pwdata[ST_TX_ACTIVITY_FLAG] && !txTraffic[0]) |=> !tx_activity_flag_reg[0])
    else $error("Transmit activity flag not cleared by write one.");

  AST_OVR_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    (wrEn && regIdx == IDX_OVR_P1) |=> portPhyAddr[0] == $past(pwdata[4:0]))
    else $error("PHY address write not stored.");

  AST_STAT_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    ##1 statWord[1][8:0] == $past(pollResult[1]))
    else $error("Polled status does not follow the polling result.");

  AST_STAT_P5: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    ##1 statWord[3][8:0] == $past(pollResult[3]))
    else $error("Port 5 status does not follow the polling result.");

  AST_RX_ACTIVITY_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (statHit[0] && pwdata[ST_RX_ACTIVITY_FLAG] && !rxTraffic[0]) |=> !rx_activity_flag_reg[0])
    else $error("Receive activity flag not cleared by write one.");

  AST_ACT_SET_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (statHit[0] && pwdata[ST_RX_ACTIVITY_FLAG] && rxTraffic[0]) |=> rx_activity_flag_reg[0])
    else $error("Clear of receive activity beat a traffic strobe.");

  AST_TX_ACTIVITY_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    txTraffic[0] |=> tx_activity_flag_reg[0])
    else $error("Transmit activity flag not set by traffic.");

  AST_ACT_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (!rx_activity_flag_reg[0] && !rxTraffic[0]) |=> !rx_activity_flag_reg[0])
    else $error("Receive activity flag set without traffic.");

  AST_OVR2_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    (wrEn && regIdx == IDX_OVR_P2) |=> portPhyAddr[1] == $past(pwdata[4:0]))
    else $error("Port 2 PHY address write not stored.");

  AST_OVR_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    !wrEn |=> $stable(ovr_reg))
    else $error("Override register changed without a write.");

  AST_CTRL_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (wrEn && regIdx == IDX_CTRL) |=> pollEnable == $past(pwdata[CTRL_POLL_EN]))
    else $error("Autopolling enable write not stored.");

  AST_ERR_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pready && pwrite && pslverr) |=>
      ($stable(ovr_reg) && $stable(pollEnable_reg) && $stable(irqEn_reg)))
    else $error("Refused write changed a register.");

  // A transfer takes two steps: setup, then the access phase that must be answered at once.
  sequence sApbSetup;
    psel && !penable;
  endsequence

  sequence sApbAccess;
    psel && penable;
  endsequence

  AST_APB_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sApbSetup ##1 sApbAccess |-> (pready && apbState_reg == APB_ACCESS))
    else $error("Access phase not answered in its first cycle.");

  AST_RD_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rdEn |=> prdata == $past(prdata_next))
    else $error("Read data not captured at the setup edge.");

  AST_RD_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pready |=> prdata == '0)
    else $error("Read data left standing after the transfer.");

  AST_IRQ_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    irqEvent[0] |=> irqStat_reg[0])
    else $error("Interrupt status not set by traffic.");

  AST_IRQ_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqClr[NUM_STAT] && !irqEvent[NUM_STAT]) |=> !irqStat_reg[NUM_STAT])
    else $error("Interrupt status not cleared by write one.");

endmodule
